// ===== pfs_cpu_model.sv
`timescale 1ns/100ps
module pfs_cpu_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic req,
	input wire logic [3:0] lat,
	input wire logic ok_in,
	input wire logic [3:0] src_in,
	input wire logic [3:0] mis_in,
	output logic done,
	output logic ok,
	output logic [3:0] src,
	output logic [3:0] mis
);
	logic [4:0] cnt;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt <= '0;
			done <= 1'b0;
			ok <= 1'b0;
			src <= 4'h5;
			mis <= 4'ha;
		end else begin
			done <= cnt == 5'h1;
			if (req) begin
				cnt <= {1'b0, lat} + 5'h1;
			end else if (cnt != '0) begin
				cnt <= cnt - 5'h1;
			end
			if (cnt == 5'h1) begin
				ok <= ok_in;
				src <= src_in;
				mis <= mis_in;
			end else begin
				// Results invalid outside the answer cycle
				ok <= ~ok;
				src <= ~src;
				mis <= ~mis;
			end
		end
	end
endmodule : pfs_cpu_model

// ===== pfs_monitor.sv
`timescale 1ns/100ps
// Contract
// - Firmware health sensor: type 28h, sensor specific, auto rearm, offset 04h both edges.
// - Count consecutive read errors per sensor; fail after ten; success clears count.
// - Processor status offsets stay set until rearm, power cycle, reset or boot.
// - Device detects thermal trip and presence; firmware reports offsets 3 and 5.
// - At controller init clear presence, then set it from detected presence.
// - Re-evaluate presence at every DC power-on and system reset.
// - Presence not kept over AC loss; no presence deassertion after AC return.
// - Check population fault at startup and DC power-on; beep when found there. The code beeps only when the fault is found at DC power-on.
// - Per CPU, assert timeout when fatal IO line high over 90 seconds.
// - On fatal IO timeout log event and reset system unless host option suppresses.
// - Timeout sensor: reading 03h, type 07h, auto rearm, offset 01h both edges.
// - Catastrophic line: act only on held low, ignore short low pulses.
// - On held low, log catastrophic event, then query CPUs for source and mismatch. The code queries first and logs the event once the answer arrives.
// - On mismatch log mismatch event, fault LED on, beep, leave system hung.
// - No mismatch: reset system unless host option disables it.
// - Catastrophic sensor rearmed only at power-on, never on system reset.
// - Data byte two: 0 unknown, 1 catastrophic, 2 core, 3 mismatch; unknown if query fails.
// - Data byte three: bitmap of causing CPUs, bit 0 first CPU.
// - Catastrophic sensor: reading 03h, type 07h, manual rearm, offset 01h both edges.
// - Mismatch sensor: manual rearm digital, offset 01h, rearmed on power-on.
module pfs_monitor
	import pfs_pkg::*;
#(
	parameter int NCPU = 4,
	parameter int NSENS = 8,
	parameter logic [IO_CNT_W-1:0] IO_TIMEOUT_CYC = IO_CNT_W'(FATAL_IO_TIMEOUT_CYC)
) (
	input wire logic CLK,
	input wire logic RST,
	input wire logic [7:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [31:0] RDATA,
	input wire logic DC_ON,
	input wire logic SYS_RESET,
	input wire logic SYS_BOOT,
	input wire logic [NCPU-1:0] CPU_PRESENT,
	input wire logic [NCPU-1:0] THERMAL_TRIP,
	input wire logic POP_FAULT,
	input wire logic [NCPU-1:0] FATAL_IO_ERROR_LINE,
	input wire logic CATASTROPHIC_ERROR_LINE_N,
	input wire logic SENSOR_READ_VALID,
	input wire logic SENSOR_READ_FAIL,
	input wire logic [7:0] SENSOR_READ_NUM,
	output logic QUERY_REQ,
	input wire logic QUERY_DONE,
	input wire logic QUERY_OK,
	input wire logic [NCPU-1:0] QUERY_SOURCE,
	input wire logic [NCPU-1:0] QUERY_MISMATCH,
	output logic EVT_VALID,
	output logic [7:0] EVT_SENSOR,
	output logic [7:0] EVT_SENSOR_TYPE,
	output logic [7:0] EVT_READING_TYPE,
	output logic [7:0] EVT_OFFSET,
	output logic EVT_DEASSERT,
	output logic [7:0] EVT_DATA_BYTE_TWO,
	output logic [7:0] EVT_DATA_BYTE_THREE,
	output logic BEEP_VALID,
	output logic [1:0] BEEP_CODE,
	output logic CPU_FAULT_LED,
	output logic SYS_RESET_REQ
);
	localparam int TW = 4 + NCPU + PROC_BITS * NCPU;
	// Bit positions of the sensors in the tracked vector
	localparam int EV_HEALTH = 0;
	localparam int EV_POP = 1;
	localparam int EV_IOT = 2;
	localparam int EV_CATASTROPHIC_ERROR_LINE = EV_IOT + NCPU;
	localparam int EV_MISMATCH = EV_CATASTROPHIC_ERROR_LINE + 1;
	localparam int EV_PROC = EV_MISMATCH + 1;

	typedef struct packed {
		logic [31:0] rdata;
		logic io_rst_dis;
		logic cat_rst_dis;
		logic [QUAL_W-1:0] qual;
		logic [NCPU-1:0][PROC_BITS-1:0] proc;
		logic [NCPU-1:0] iot;
		logic [NCPU-1:0][IO_CNT_W-1:0] io_cnt;
		logic [QUAL_W-1:0] cat_cnt;
		pfs_cat_state_type cat_st;
		logic catastrophic_error_line;
		logic mismatch;
		logic [7:0] ed2;
		logic [7:0] ed3;
		logic pop;
		logic health;
		logic [7:0] health_num;
		logic [NSENS-1:0][3:0] rd_cnt;
		logic [TW-1:0] rep;
		logic init_done;
		logic query_req;
		logic evt_valid;
		logic [7:0] evt_sensor;
		logic [7:0] evt_stype;
		logic [7:0] evt_rtype;
		logic [7:0] evt_offset;
		logic evt_deassert;
		logic [7:0] evt_d2;
		logic [7:0] evt_d3;
		logic beep_valid;
		logic [1:0] beep_code;
		logic led;
		logic sys_rst;
	} pfs_state_type;

	pfs_state_type s_r;
	pfs_state_type s_nxt;

	always_comb begin
		logic [TW-1:0] trk;
		logic found;
		logic any_fail;
		logic [7:0] fail_num;
		logic pwr_clear;
		logic eval_pres;
		logic eval_pop;
		logic rearm_wr;
		int c;
		int k;
		trk = '0;
		found = 1'b0;
		any_fail = 1'b0;
		fail_num = 8'h00;
		pwr_clear = DC_ON | SYS_RESET | SYS_BOOT;
		eval_pres = DC_ON | SYS_RESET | !s_r.init_done;
		eval_pop = DC_ON | !s_r.init_done;
		rearm_wr = WR && ADDR == REG_REARM;
		c = 0;
		k = 0;
		s_nxt = s_r;
		s_nxt.init_done = 1'b1;
		s_nxt.query_req = 1'b0;
		s_nxt.evt_valid = 1'b0;
		s_nxt.beep_valid = 1'b0;
		s_nxt.sys_rst = 1'b0;
		s_nxt.rdata = 32'h0000_0000;

		// Register writes
		if (WR) begin
			case (ADDR)
				REG_CTRL: begin
					s_nxt.io_rst_dis = WDATA[CTRL_IO_RST_DIS];
					s_nxt.cat_rst_dis = WDATA[CTRL_CAT_RST_DIS];
				end
				REG_QUAL: s_nxt.qual = WDATA[QUAL_W-1:0];
				default: ;
			endcase
		end

		// Processor status offsets; clears first so that sets win
		for (int i = 0; i < NCPU; i++) begin
			if (pwr_clear || (rearm_wr && WDATA[i])) begin
				s_nxt.proc[i][PK_THERM] = 1'b0;
				s_nxt.proc[i][PK_HANG] = 1'b0;
				s_nxt.proc[i][PK_CFG] = 1'b0;
			end
			if (THERMAL_TRIP[i]) begin
				s_nxt.proc[i][PK_THERM] = 1'b1;
			end
			if (WR && ADDR == REG_HOST_REPORT) begin
				if (WDATA[HOST_HANG_LSB + i]) begin
					s_nxt.proc[i][PK_HANG] = 1'b1;
				end
				if (WDATA[HOST_CFG_LSB + i]) begin
					s_nxt.proc[i][PK_CFG] = 1'b1;
				end
			end
			if (eval_pres) begin
				s_nxt.proc[i][PK_PRES] = CPU_PRESENT[i];
			end
		end

		// Population fault
		// System reset leaves the population fault as it was
		if (eval_pop) begin
			s_nxt.pop = POP_FAULT;
		end
		if (DC_ON && POP_FAULT) begin
			s_nxt.beep_valid = 1'b1;
			s_nxt.beep_code = BEEP_POP;
		end

		// Fatal IO error timeout per CPU, auto rearm
		for (int i = 0; i < NCPU; i++) begin
			if (!FATAL_IO_ERROR_LINE[i]) begin
				s_nxt.io_cnt[i] = '0;
				s_nxt.iot[i] = 1'b0;
			end else begin
				// Saturates so a stuck line cannot wrap and fire again
				if (s_r.io_cnt[i] < IO_TIMEOUT_CYC) begin
					s_nxt.io_cnt[i] = s_r.io_cnt[i] + IO_CNT_W'(1);
				end
				if (s_r.io_cnt[i] >= IO_TIMEOUT_CYC && !s_r.iot[i]) begin
					s_nxt.iot[i] = 1'b1;
					if (!s_r.io_rst_dis) begin
						s_nxt.sys_rst = 1'b1;
					end
				end
			end
		end

		// Power-on rearm first, so an answer in the same cycle still lands
		if (DC_ON) begin
			s_nxt.cat_st = CAT_IDLE;
			s_nxt.cat_cnt = '0;
			s_nxt.catastrophic_error_line = 1'b0;
			s_nxt.mismatch = 1'b0;
			s_nxt.led = 1'b0;
		end

		// Catastrophic error qualification and query
		case (s_r.cat_st)
			CAT_IDLE: begin
				if (CATASTROPHIC_ERROR_LINE_N) begin
					s_nxt.cat_cnt = '0;
				end else if (s_r.cat_cnt >= s_r.qual) begin
					s_nxt.cat_st = CAT_QUERY;
					s_nxt.query_req = 1'b1;
				end else begin
					s_nxt.cat_cnt = s_r.cat_cnt + QUAL_W'(1);
				end
			end
			CAT_QUERY: begin
				if (QUERY_DONE) begin
					s_nxt.cat_st = CAT_LATCHED;
					s_nxt.catastrophic_error_line = 1'b1;
					if (QUERY_OK) begin
						s_nxt.ed3 = 8'(QUERY_SOURCE);
					end else begin
						s_nxt.ed3 = 8'h00;
					end
					if (!QUERY_OK) begin
						s_nxt.ed2 = CAT_UNKNOWN;
					end else if (|QUERY_MISMATCH) begin
						s_nxt.ed2 = CAT_MISMATCH;
					end else begin
						s_nxt.ed2 = CAT_CATASTROPHIC_ERROR_LINE;
					end
					if (QUERY_OK && |QUERY_MISMATCH) begin
						s_nxt.mismatch = 1'b1;
						s_nxt.led = 1'b1;
						s_nxt.beep_valid = 1'b1;
						s_nxt.beep_code = BEEP_MISMATCH;
					end else if (!s_r.cat_rst_dis) begin
						s_nxt.sys_rst = 1'b1;
					end
				end
			end
			// Further lows wait for the power-on rearm
			CAT_LATCHED: ;
			default: s_nxt.cat_st = CAT_IDLE;
		endcase

		// Read error counting for firmware health
		if (SENSOR_READ_VALID && SENSOR_READ_NUM < 8'(NSENS)) begin
			for (int i = 0; i < NSENS; i++) begin
				if (SENSOR_READ_NUM == 8'(i)) begin
					if (!SENSOR_READ_FAIL) begin
						s_nxt.rd_cnt[i] = 4'h0;
					end else if (s_r.rd_cnt[i] < READ_ERR_LIMIT) begin
						s_nxt.rd_cnt[i] = s_r.rd_cnt[i] + 4'h1;
					end
				end
			end
		end
		for (int i = NSENS - 1; i >= 0; i--) begin
			if (s_nxt.rd_cnt[i] == READ_ERR_LIMIT) begin
				any_fail = 1'b1;
				fail_num = 8'(i);
			end
		end
		s_nxt.health = any_fail;
		if (any_fail && !s_r.health) begin
			s_nxt.health_num = fail_num;
		end

		// Event records, one change per cycle
		// Changes not yet reported wait in rep, lowest index first
		trk[EV_HEALTH] = s_r.health;
		trk[EV_POP] = s_r.pop;
		trk[EV_IOT +: NCPU] = s_r.iot;
		trk[EV_CATASTROPHIC_ERROR_LINE] = s_r.catastrophic_error_line;
		trk[EV_MISMATCH] = s_r.mismatch;
		trk[EV_PROC +: PROC_BITS * NCPU] = s_r.proc;
		for (int i = 0; i < TW; i++) begin
			if (!found && trk[i] != s_r.rep[i]) begin
				found = 1'b1;
				s_nxt.rep[i] = trk[i];
				s_nxt.evt_valid = 1'b1;
				s_nxt.evt_deassert = !trk[i];
				s_nxt.evt_d2 = 8'h00;
				s_nxt.evt_d3 = 8'h00;
				s_nxt.evt_stype = STYPE_PROC;
				s_nxt.evt_rtype = RTYPE_DIGITAL;
				s_nxt.evt_offset = OFS_STATE_ASSERTED;
				if (i == EV_HEALTH) begin
					s_nxt.evt_sensor = SNS_HEALTH;
					s_nxt.evt_stype = STYPE_HEALTH;
					s_nxt.evt_rtype = RTYPE_SPECIFIC;
					s_nxt.evt_offset = OFS_SENSOR_FAIL;
					s_nxt.evt_d2 = s_r.health_num;
				end else if (i == EV_POP) begin
					s_nxt.evt_sensor = SNS_POP;
				end else if (i < EV_CATASTROPHIC_ERROR_LINE) begin
					s_nxt.evt_sensor = SNS_IOTO_BASE + 8'(i - EV_IOT);
				end else if (i == EV_CATASTROPHIC_ERROR_LINE) begin
					s_nxt.evt_sensor = SNS_CATASTROPHIC_ERROR_LINE;
					s_nxt.evt_d2 = s_r.ed2;
					s_nxt.evt_d3 = s_r.ed3;
				end else if (i == EV_MISMATCH) begin
					s_nxt.evt_sensor = SNS_MISMATCH;
				end else begin
					c = (i - EV_PROC) / PROC_BITS;
					k = (i - EV_PROC) % PROC_BITS;
					s_nxt.evt_sensor = SNS_PROC_BASE + 8'(c);
					s_nxt.evt_rtype = RTYPE_SPECIFIC;
					s_nxt.evt_offset = PROC_OFFS[k];
				end
			end
		end

		// Register reads, data in the following cycle
		// Write-only and unmapped addresses read as zero
		if (RD) begin
			case (ADDR)
				REG_CTRL: begin
					s_nxt.rdata[CTRL_IO_RST_DIS] = s_r.io_rst_dis;
					s_nxt.rdata[CTRL_CAT_RST_DIS] = s_r.cat_rst_dis;
				end
				REG_QUAL: s_nxt.rdata[QUAL_W-1:0] = s_r.qual;
				REG_STATUS: begin
					s_nxt.rdata[STAT_PROC_LSB +: PROC_BITS * NCPU] = s_r.proc;
					s_nxt.rdata[STAT_IOT_LSB +: NCPU] = s_r.iot;
					s_nxt.rdata[STAT_CATASTROPHIC_ERROR_LINE] = s_r.catastrophic_error_line;
					s_nxt.rdata[STAT_MISMATCH] = s_r.mismatch;
					s_nxt.rdata[STAT_POP] = s_r.pop;
					s_nxt.rdata[STAT_HEALTH] = s_r.health;
					s_nxt.rdata[STAT_LED] = s_r.led;
				end
				default: ;
			endcase
		end
	end

	// Reset stands for AC power-on: reported copy starts cleared
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			s_r <= '0;
			s_r.qual <= QUAL_RST;
			s_r.cat_st <= CAT_IDLE;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign RDATA = s_r.rdata;
	assign QUERY_REQ = s_r.query_req;
	assign EVT_VALID = s_r.evt_valid;
	assign EVT_SENSOR = s_r.evt_sensor;
	assign EVT_SENSOR_TYPE = s_r.evt_stype;
	assign EVT_READING_TYPE = s_r.evt_rtype;
	assign EVT_OFFSET = s_r.evt_offset;
	assign EVT_DEASSERT = s_r.evt_deassert;
	assign EVT_DATA_BYTE_TWO = s_r.evt_d2;
	assign EVT_DATA_BYTE_THREE = s_r.evt_d3;
	assign BEEP_VALID = s_r.beep_valid;
	assign BEEP_CODE = s_r.beep_code;
	assign CPU_FAULT_LED = s_r.led;
	assign SYS_RESET_REQ = s_r.sys_rst;
endmodule : pfs_monitor

// ===== pfs_monitor_properties.sv
`timescale 1ns/100ps
module pfs_monitor_checker
	import pfs_pkg::*;
(
	input wire logic CLK,
	input wire logic RST,
	input wire logic DC_ON,
	input wire logic CATASTROPHIC_ERROR_LINE_N,
	input wire logic QUERY_REQ,
	input wire logic EVT_VALID,
	input wire logic [7:0] EVT_SENSOR,
	input wire logic [7:0] EVT_SENSOR_TYPE,
	input wire logic [7:0] EVT_READING_TYPE,
	input wire logic [7:0] EVT_OFFSET,
	input wire logic [7:0] EVT_DATA_BYTE_TWO,
	input wire logic BEEP_VALID,
	input wire logic [1:0] BEEP_CODE,
	input wire logic CPU_FAULT_LED,
	input wire logic SYS_RESET_REQ
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RST);
	logic [7:0] s;
	// Sensor of the current event, zero when idle
	assign s = EVT_VALID ? EVT_SENSOR : 8'h00;
	query_pulse_a: assert property (QUERY_REQ |=> !QUERY_REQ)
		else $error("query request too long");
	qual_low_a: assert property (QUERY_REQ |->
		!$past(CATASTROPHIC_ERROR_LINE_N) && !$past(CATASTROPHIC_ERROR_LINE_N, 2))
		else $error("query without held low line");
	health_fields_a: assert property (s == SNS_HEALTH |->
		EVT_SENSOR_TYPE == 8'h28 && EVT_READING_TYPE == 8'h6f && EVT_OFFSET == 8'h04)
		else $error("health event fields wrong");
	iot_fields_a: assert property (s[7:2] == 6'h04 |->
		EVT_SENSOR_TYPE == 8'h07 && EVT_READING_TYPE == 8'h03 && EVT_OFFSET == 8'h01)
		else $error("timeout event fields wrong");
	cat_fields_a: assert property (s == SNS_CATASTROPHIC_ERROR_LINE |-> EVT_SENSOR_TYPE == 8'h07 && EVT_READING_TYPE == 8'h03
		&& EVT_OFFSET == 8'h01 && EVT_DATA_BYTE_TWO inside {8'h00, 8'h01, 8'h03})
		else $error("catastrophic event fields wrong");
	mis_fields_a: assert property (s == SNS_MISMATCH |->
		EVT_SENSOR_TYPE == 8'h07 && EVT_READING_TYPE == 8'h03 && EVT_OFFSET == 8'h01)
		else $error("mismatch event fields wrong");
	led_hold_a: assert property (CPU_FAULT_LED && !DC_ON |=> CPU_FAULT_LED)
		else $error("fault led dropped");
	hang_beep_a: assert property ($rose(CPU_FAULT_LED) |->
		BEEP_VALID && BEEP_CODE == BEEP_MISMATCH && !SYS_RESET_REQ ##1 !SYS_RESET_REQ [*3])
		else $error("mismatch without beep or with reset");
	cover property (s == SNS_CATASTROPHIC_ERROR_LINE);
	cover property (s == SNS_HEALTH);
	cover property ($rose(CPU_FAULT_LED));
endmodule : pfs_monitor_checker
bind pfs_monitor pfs_monitor_checker u_chk (.CLK(CLK), .RST(RST), .DC_ON(DC_ON),
	.CATASTROPHIC_ERROR_LINE_N(CATASTROPHIC_ERROR_LINE_N), .QUERY_REQ(QUERY_REQ), .EVT_VALID(EVT_VALID),
	.EVT_SENSOR(EVT_SENSOR), .EVT_SENSOR_TYPE(EVT_SENSOR_TYPE), .EVT_READING_TYPE(EVT_READING_TYPE),
	.EVT_OFFSET(EVT_OFFSET), .EVT_DATA_BYTE_TWO(EVT_DATA_BYTE_TWO), .BEEP_VALID(BEEP_VALID),
	.BEEP_CODE(BEEP_CODE), .CPU_FAULT_LED(CPU_FAULT_LED), .SYS_RESET_REQ(SYS_RESET_REQ));

// ===== pfs_monitor_tb_top.sv
`timescale 1ns/100ps
module pfs_monitor_tb_top
	import pfs_pkg::*;
;
	logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, dc_on = 1'b0, sys_rst = 1'b0, pop = 1'b0, cat_n = 1'b1;
	logic rv = 1'b0, rf = 1'b0, q_ok = 1'b0, rd_d = 1'b0, qreq, qdone, qok, ev_v, ev_d, bv, led, rreq;
	logic [7:0] addr = '0, rnum = '0, es, eo, e2, e3;
	logic [31:0] wdata = '0, pm = '0, rdata;
	logic [3:0] pres = '0, trip = '0, fio = '0, q_src = '0, q_mis = '0, q_lat = '0, src, mis;
	logic [1:0] bc;
	logic sys_boot = 1'b0;
	logic [15:0] ed;
	logic [39:0] eq[$];
	logic [31:0] rq[$];
	logic [1:0] bq[$];
	int err_count = 0, comparisons = 0, rr = 0, rrx = 0;
	pfs_monitor #(.IO_TIMEOUT_CYC(36'd20)) dut (.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
		.RDATA(rdata), .DC_ON(dc_on), .SYS_RESET(sys_rst), .SYS_BOOT(sys_boot), .CPU_PRESENT(pres),
		.THERMAL_TRIP(trip),
		.POP_FAULT(pop), .FATAL_IO_ERROR_LINE(fio), .CATASTROPHIC_ERROR_LINE_N(cat_n), .SENSOR_READ_VALID(rv),
		.SENSOR_READ_FAIL(rf), .SENSOR_READ_NUM(rnum), .QUERY_REQ(qreq), .QUERY_DONE(qdone), .QUERY_OK(qok),
		.QUERY_SOURCE(src), .QUERY_MISMATCH(mis), .EVT_VALID(ev_v), .EVT_SENSOR(es), .EVT_SENSOR_TYPE(),
		.EVT_READING_TYPE(), .EVT_OFFSET(eo), .EVT_DEASSERT(ev_d), .EVT_DATA_BYTE_TWO(e2),
		.EVT_DATA_BYTE_THREE(e3), .BEEP_VALID(bv), .BEEP_CODE(bc), .CPU_FAULT_LED(led), .SYS_RESET_REQ(rreq));
	pfs_cpu_model cpu (.clk(clk), .rst(rst), .req(qreq), .lat(q_lat), .ok_in(q_ok), .src_in(q_src), .mis_in(q_mis),
		.done(qdone), .ok(qok), .src(src), .mis(mis));
	always #4 clk = ~clk;
	task chk(input logic [39:0] seen, input logic [39:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task test_done;
		$display("errors %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : test_done
	task ev(input logic [7:0] s, o, input logic d, input logic [7:0] x2 = 8'h0, x3 = 8'h0);
		eq.push_back({s, o, 7'h0, d, x2, x3});
	endtask : ev
	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	task reg_wr(input logic [7:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask : reg_wr
	task reg_rd(input logic [7:0] a, input logic [31:0] x);
		rq.push_back(x);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
	endtask : reg_rd
	task drain;
		for (int i = 0; i < 80 && eq.size() + bq.size() != 0; i++) begin
			@(posedge clk);
		end
		cyc(4);
		chk(40'(eq.size() + bq.size()), 40'h0);
		chk(40'(rr), 40'(rrx));
	endtask : drain
	task cat(input logic ok, input logic [3:0] s, m);
		q_ok <= ok;
		q_src <= s;
		q_mis <= m;
		cat_n <= 1'b0;
		cyc(30);
		cat_n <= 1'b1;
		drain();
	endtask : cat
	task dc_pulse;
		dc_on <= 1'b1;
		@(posedge clk);
		dc_on <= 1'b0;
		drain();
	endtask : dc_pulse
	always @(posedge clk) begin
		if (rd_d) begin
			chk(40'(rdata), 40'(rq.pop_front()));
		end
		rd_d <= rd;
		if (rreq === 1'b1) begin
			rr++;
		end
		if (bv === 1'b1) begin
			chk(40'(bc), bq.size() != 0 ? 40'(bq.pop_front()) : '1);
		end
		if (ev_v === 1'b1) begin
			ed = (ev_d || (es != SNS_CATASTROPHIC_ERROR_LINE && es != SNS_HEALTH)) ? 16'h0 : {e2, es == SNS_CATASTROPHIC_ERROR_LINE ? e3 : 8'h0};
			chk({es, es == SNS_POP ? 8'h0 : eo, 7'h0, ev_d, ed}, eq.size() != 0 ? eq.pop_front() : '1);
		end
	end
	initial begin
		#100_000;
		err_count++;
		test_done();
	end
	initial begin
		void'($urandom(8));
		@(posedge clk);
		pres <= 4'($urandom());
		rnum <= 8'($urandom() % 8);
		q_lat <= 4'($urandom() % 8);
		repeat (2) @(posedge clk);
		for (int i = 0; i < 4; i++) begin
			if (pres[i]) begin
				ev(SNS_PROC_BASE | 8'(i), 8'h07, 1'b0);
				pm[4*i+3] = 1'b1;
			end
		end
		rst <= 1'b0;
		drain();
		reg_rd(REG_QUAL, 32'(QUAL_RST));
		reg_rd(8'h20, 32'h0);
		reg_rd(REG_REARM, 32'h0);
		ev(SNS_PROC_BASE | 8'h1, 8'h01, 1'b0);
		trip <= 4'h2;
		cyc(2);
		trip <= 4'h0;
		ev(SNS_PROC_BASE, 8'h03, 1'b0);
		ev(SNS_PROC_BASE | 8'h1, 8'h05, 1'b0);
		reg_wr(REG_HOST_REPORT, 32'h21);
		drain();
		reg_rd(REG_STATUS, pm | 32'h52);
		ev(SNS_PROC_BASE, 8'h03, 1'b1);
		ev(SNS_PROC_BASE | 8'h1, 8'h01, 1'b1);
		ev(SNS_PROC_BASE | 8'h1, 8'h05, 1'b1);
		reg_wr(REG_REARM, 32'h3);
		drain();
		// Short fatal IO assertion stays silent
		fio <= 4'h1;
		cyc(15);
		fio <= 4'h0;
		cyc(2);
		for (int p = 0; p < 2; p++) begin
			reg_wr(REG_CTRL, 32'(p));
			ev(SNS_IOTO_BASE | 8'(2 + p), 8'h01, 1'b0);
			ev(SNS_IOTO_BASE | 8'(2 + p), 8'h01, 1'b1);
			rrx += 1 - p;
			fio <= 4'(4 << p);
			cyc(30);
			fio <= 4'h0;
			drain();
		end
		reg_rd(REG_CTRL, 32'h1);
		reg_wr(REG_QUAL, 32'h4);
		cat_n <= 1'b0;
		cyc(4);
		cat_n <= 1'b1;
		cyc(8);
		ev(SNS_CATASTROPHIC_ERROR_LINE, 8'h01, 1'b0, 8'h01, 8'h02);
		rrx++;
		cat(1'b1, 4'h2, 4'h0);
		// Boot, then system reset, each clears a thermal trip
		for (int b = 0; b < 2; b++) begin
			ev(SNS_PROC_BASE, 8'h01, 1'b0);
			ev(SNS_PROC_BASE, 8'h01, 1'b1);
			trip <= 4'h1;
			cyc(2);
			trip <= 4'h0;
			cyc(3);
			sys_boot <= !b;
			sys_rst <= 1'(b);
			@(posedge clk);
			sys_boot <= 1'b0;
			sys_rst <= 1'b0;
		end
		cat(1'b1, 4'h1, 4'h0);
		pop <= 1'b1;
		ev(SNS_POP, 8'h0, 1'b0);
		ev(SNS_CATASTROPHIC_ERROR_LINE, 8'h01, 1'b1);
		bq.push_back(BEEP_POP);
		dc_pulse();
		ev(SNS_CATASTROPHIC_ERROR_LINE, 8'h01, 1'b0, 8'h03, 8'h08);
		ev(SNS_MISMATCH, 8'h01, 1'b0);
		bq.push_back(BEEP_MISMATCH);
		cat(1'b1, 4'h8, 4'h8);
		chk(40'(led), 40'h1);
		pop <= 1'b0;
		reg_wr(REG_CTRL, 32'h3);
		ev(SNS_POP, 8'h0, 1'b1);
		ev(SNS_CATASTROPHIC_ERROR_LINE, 8'h01, 1'b1);
		ev(SNS_MISMATCH, 8'h01, 1'b1);
		dc_pulse();
		chk(40'(led), 40'h0);
		ev(SNS_CATASTROPHIC_ERROR_LINE, 8'h01, 1'b0);
		cat(1'b0, 4'h0, 4'h0);
		ev(SNS_HEALTH, 8'h04, 1'b0, rnum);
		ev(SNS_HEALTH, 8'h04, 1'b1);
		rv <= 1'b1;
		for (int k = 0; k < 21; k++) begin
			rf <= !(k == 9 || k == 20);
			@(posedge clk);
		end
		rv <= 1'b0;
		drain();
		test_done();
	end
endmodule : pfs_monitor_tb_top

// ===== pfs_pkg.sv
package pfs_pkg;
	// Timing
	localparam longint CLK_HZ = 125_000_000;
	localparam longint FATAL_IO_TIMEOUT_S = 90;
	localparam longint FATAL_IO_TIMEOUT_CYC = FATAL_IO_TIMEOUT_S * CLK_HZ;
	localparam longint CATASTROPHIC_ERROR_LINE_QUAL_US = 100;
	localparam longint CATASTROPHIC_ERROR_LINE_QUAL_CYC = (CATASTROPHIC_ERROR_LINE_QUAL_US * CLK_HZ + 999_999) / 1_000_000;
	localparam int IO_CNT_W = 36;
	localparam int QUAL_W = 16;
	localparam logic [QUAL_W-1:0] QUAL_RST = QUAL_W'(CATASTROPHIC_ERROR_LINE_QUAL_CYC);
	localparam logic [3:0] READ_ERR_LIMIT = 4'ha;

	// Register byte addresses
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_QUAL = 8'h04;
	localparam logic [7:0] REG_HOST_REPORT = 8'h08;
	localparam logic [7:0] REG_REARM = 8'h0c;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam int CTRL_IO_RST_DIS = 0;
	localparam int CTRL_CAT_RST_DIS = 1;
	localparam int HOST_HANG_LSB = 0;
	localparam int HOST_CFG_LSB = 4;
	localparam int STAT_PROC_LSB = 0;
	localparam int STAT_IOT_LSB = 16;
	localparam int STAT_CATASTROPHIC_ERROR_LINE = 20;
	localparam int STAT_MISMATCH = 21;
	localparam int STAT_POP = 22;
	localparam int STAT_HEALTH = 23;
	localparam int STAT_LED = 24;

	// Sensor identities, types and offsets
	localparam logic [7:0] SNS_HEALTH = 8'h01;
	localparam logic [7:0] SNS_POP = 8'h02;
	localparam logic [7:0] SNS_IOTO_BASE = 8'h10;
	localparam logic [7:0] SNS_CATASTROPHIC_ERROR_LINE = 8'h20;
	localparam logic [7:0] SNS_MISMATCH = 8'h21;
	localparam logic [7:0] SNS_PROC_BASE = 8'h30;
	localparam logic [7:0] STYPE_HEALTH = 8'h28;
	localparam logic [7:0] STYPE_PROC = 8'h07;
	localparam logic [7:0] RTYPE_SPECIFIC = 8'h6f;
	localparam logic [7:0] RTYPE_DIGITAL = 8'h03;
	localparam logic [7:0] OFS_SENSOR_FAIL = 8'h04;
	localparam logic [7:0] OFS_STATE_ASSERTED = 8'h01;
	localparam logic [3:0][7:0] PROC_OFFS = {8'h07, 8'h05, 8'h03, 8'h01};
	localparam int PK_THERM = 0;
	localparam int PK_HANG = 1;
	localparam int PK_CFG = 2;
	localparam int PK_PRES = 3;
	localparam int PROC_BITS = 4;

	// Catastrophic error type in event data byte two
	localparam logic [7:0] CAT_UNKNOWN = 8'h00;
	localparam logic [7:0] CAT_CATASTROPHIC_ERROR_LINE = 8'h01;
	localparam logic [7:0] CAT_CORE = 8'h02;
	localparam logic [7:0] CAT_MISMATCH = 8'h03;

	localparam logic [1:0] BEEP_POP = 2'h1;
	localparam logic [1:0] BEEP_MISMATCH = 2'h2;

	typedef enum logic [1:0] {
		CAT_IDLE = 2'b00,
		CAT_QUERY = 2'b01,
		CAT_LATCHED = 2'b10
	} pfs_cat_state_type;
endpackage : pfs_pkg
